//--- rtl/isc_i2c_master.sv
/*
  isc_i2c_master: single-master two-wire controller with byte queue.
  Assumes the register port is synchronous to mclk_i and the pins are
  open-drain with external pull-ups.
*/
// Operation
// - Acts only as the sole bus master; no arbitration.
// - Standard and fast rates up to 400 kHz via divider.
// - Transmit and receive paths are each double-buffered.
// - Any byte, general-call or start byte, may follow a START.
// - A slave holding SCL low stalls the bit until released.
// - Byte port writes push transmit bytes, reads pop received bytes.
// - Control and flag bits 7:5 read zero; writes ignored.
// - Control bit 4 gates the interrupt request.
// - Writing one to control bit 3 queues a START.
// - Writing one to control bit 2 queues a STOP.
// - Control bit 1 sets the level driven in receive acknowledge.
// - Control bit 0 enables the controller; resets to zero.
// - Flag bit 4 shows the condition queue is not empty.
// - Flag bit 3 shows bus busy between START and STOP.
// - Flag bit 2 is one when no byte, START or STOP is in progress.
// - Flag bit 1 shows a byte held in the receive or the transmit queue.
// - Flag bit 0 holds the acknowledge level sampled last.
// - SCL rate is clock over sixteen times setting plus one.
`default_nettype none
module isc_i2c_master (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  // bus pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // interrupt
  output logic irq_o
);
  import isc_pkg::*;

  // ***********************
  // state
  // ***********************
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic [17:0] div_cnt;
    logic [15:0] scl_divider;
    logic irq_gate;
    logic reply_bit_level;
    logic unit_enable;
    logic busy;
    logic received_reply_level;
    logic rd_req;
    logic irq_flag;
    isc_state_e state;
    logic [1:0] ph;
    logic [3:0] bit_idx;
    logic rx_mode;
    logic [7:0] shift;
    logic scl_low;
    logic sda_low;
    logic pin_zero;
    logic irq_out;
    logic [15:0] rdata;
  } isc_state_s;

  isc_state_s s;
  isc_state_s next_s;

  logic tick;
  logic scl_high;
  logic sda_level;
  logic evt;
  logic hit_byte;
  logic hit_ctrl;
  logic hit_flags;
  logic hit_div;
  logic do_wr;
  logic do_rd;
  logic tx_in_valid;
  logic tx_valid;
  logic tx_take;
  logic [7:0] tx_data;
  logic rx_push;
  logic rx_in_ready;
  logic rx_valid;
  logic rx_pop;
  logic [7:0] rx_data;
  logic cmd_in_valid;
  logic cmd_valid;
  logic cmd_pop;
  logic [1:0] cmd_head;
  logic [7:0] ctrl_view;
  logic [7:0] flag_view;

  // ***********************
  // queues
  // ***********************
  // transmit bytes from the byte port
  isc_buf2 #(.W(8)) u_tx_buf (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(tx_in_valid),
    .in_ready_o(),
    .in_data_i(reg_wdata_i[7:0]),
    .out_valid_o(tx_valid),
    .out_ready_i(tx_take),
    .out_data_o(tx_data)
  );
  // received bytes toward the byte port
  isc_buf2 #(.W(8)) u_rx_buf (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(rx_push),
    .in_ready_o(rx_in_ready),
    .in_data_i(s.shift),
    .out_valid_o(rx_valid),
    .out_ready_i(rx_pop),
    .out_data_o(rx_data)
  );
  // queued conditions, entry is {begin, end}
  isc_buf2 #(.W(2)) u_cmd_buf (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .in_valid_i(cmd_in_valid),
    .in_ready_o(),
    .in_data_i({reg_wdata_i[CTL_BEGIN], reg_wdata_i[CTL_END]}),
    .out_valid_o(cmd_valid),
    .out_ready_i(cmd_pop),
    .out_data_o(cmd_head)
  );

  // ***********************
  // register decode
  // ***********************
  assign hit_byte = (reg_addr_i == ADDR_BYTE_PORT);
  assign hit_ctrl = (reg_addr_i == ADDR_CONTROL);
  assign hit_flags = (reg_addr_i == ADDR_FLAGS);
  assign hit_div = (reg_addr_i == ADDR_DIVIDER);
  assign do_wr = reg_sel_i && reg_wr_i;
  assign do_rd = reg_sel_i && reg_rd_i;
  // a byte written while two are queued is dropped
  assign tx_in_valid = do_wr && hit_byte;
  assign rx_pop = do_rd && hit_byte;
  assign cmd_in_valid = do_wr && hit_ctrl && (reg_wdata_i[CTL_BEGIN] || reg_wdata_i[CTL_END]);
  assign scl_high = s.scl_sync[1];
  assign sda_level = s.sda_sync[1];
  assign ctrl_view = {3'h0, s.irq_gate, 2'h0, s.reply_bit_level, s.unit_enable};
  assign flag_view = {3'h0, cmd_valid, s.busy, (s.state == ST_IDLE), (rx_valid || tx_valid),
                      s.received_reply_level};

  always_comb
  begin
    next_s = s;
    tick = 1'b0;
    evt = 1'b0;
    tx_take = 1'b0;
    rx_push = 1'b0;
    cmd_pop = 1'b0;
    // two-stage pin synchronisers
    next_s.scl_sync = {s.scl_sync[0], scl_i};
    next_s.sda_sync = {s.sda_sync[0], sda_i};

    // ***********************
    // quarter-bit divider
    // ***********************
    // four quarters of 4*(n+1) clocks each give 16*(n+1) per bit
    if (!s.unit_enable)
      next_s.div_cnt = '0;
    else if (s.div_cnt >= {s.scl_divider, 2'b11})
    begin
      next_s.div_cnt = '0;
      tick = 1'b1;
    end
    else
      next_s.div_cnt = s.div_cnt + 18'h1;

    // ***********************
    // bus engine
    // ***********************
    if (!s.unit_enable)
    begin
      next_s.state = ST_IDLE;
      next_s.ph = PH_SETUP;
      next_s.busy = 1'b0;
      next_s.rd_req = 1'b0;
      next_s.scl_low = 1'b0;
      next_s.sda_low = 1'b0;
    end
    else
    begin
      unique case (s.state)
        ST_IDLE:
        begin
          next_s.ph = PH_SETUP;
          next_s.bit_idx = '0;
          if (cmd_valid)
            next_s.state = cmd_head[1] ? ST_START : ST_STOP;
          else if (s.busy && tx_valid)
          begin
            tx_take = 1'b1;
            next_s.shift = tx_data;
            next_s.rx_mode = 1'b0;
            next_s.state = ST_BYTE;
          end
          // wait for room so a received byte is never lost
          else if (s.busy && s.rd_req && rx_in_ready)
          begin
            next_s.rd_req = 1'b0;
            next_s.shift = '0;
            next_s.rx_mode = 1'b1;
            next_s.state = ST_BYTE;
          end
        end
        ST_START:
        begin
          if (tick)
          begin
            unique case (s.ph)
              PH_SETUP:
              begin
                next_s.sda_low = 1'b0;
                next_s.ph = PH_RISE;
              end
              PH_RISE:
              begin
                next_s.scl_low = 1'b0;
                next_s.ph = PH_HIGH;
              end
              PH_HIGH:
              begin
                if (scl_high)
                begin
                  next_s.sda_low = 1'b1;
                  next_s.ph = PH_FALL;
                end
              end
              PH_FALL:
              begin
                next_s.scl_low = 1'b1;
                next_s.busy = 1'b1;
                next_s.ph = PH_SETUP;
                if (cmd_head[0])
                  next_s.state = ST_STOP;
                else
                begin
                  cmd_pop = 1'b1;
                  next_s.state = ST_IDLE;
                end
              end
            endcase
          end
        end
        ST_STOP:
        begin
          // a stop on a free bus has nothing to end
          if (!s.busy)
          begin
            cmd_pop = 1'b1;
            next_s.state = ST_IDLE;
          end
          else if (tick)
          begin
            unique case (s.ph)
              PH_SETUP:
              begin
                next_s.sda_low = 1'b1;
                next_s.ph = PH_RISE;
              end
              PH_RISE:
              begin
                next_s.scl_low = 1'b0;
                next_s.ph = PH_HIGH;
              end
              PH_HIGH:
              begin
                if (scl_high)
                  next_s.ph = PH_FALL;
              end
              PH_FALL:
              begin
                next_s.sda_low = 1'b0;
                next_s.busy = 1'b0;
                next_s.ph = PH_SETUP;
                cmd_pop = 1'b1;
                next_s.state = ST_IDLE;
              end
            endcase
          end
        end
        ST_BYTE:
        begin
          if (tick)
          begin
            unique case (s.ph)
              PH_SETUP:
              begin
                if (s.bit_idx == ACK_SLOT)
                  next_s.sda_low = s.rx_mode && !s.reply_bit_level;
                else
                  next_s.sda_low = !s.rx_mode && !s.shift[7];
                next_s.ph = PH_RISE;
              end
              PH_RISE:
              begin
                next_s.scl_low = 1'b0;
                next_s.ph = PH_HIGH;
              end
              PH_HIGH:
              begin
                if (scl_high)
                begin
                  if (s.bit_idx == ACK_SLOT)
                  begin
                    if (!s.rx_mode)
                      next_s.received_reply_level = sda_level;
                  end
                  else if (s.rx_mode)
                    next_s.shift = {s.shift[6:0], sda_level};
                  next_s.ph = PH_FALL;
                end
              end
              PH_FALL:
              begin
                next_s.scl_low = 1'b1;
                next_s.ph = PH_SETUP;
                if (s.bit_idx == ACK_SLOT)
                begin
                  // sda waits for the next setup quarter; released here it races the scl fall
                  rx_push = s.rx_mode;
                  evt = 1'b1;
                  next_s.state = ST_IDLE;
                end
                else
                begin
                  if (!s.rx_mode)
                    next_s.shift = {s.shift[6:0], 1'b0};
                  next_s.bit_idx = s.bit_idx + 4'h1;
                end
              end
            endcase
          end
        end
      endcase
    end

    // ***********************
    // register writes and reads
    // ***********************
    if (do_wr && hit_ctrl)
    begin
      next_s.irq_gate = reg_wdata_i[CTL_IRQ_GATE];
      next_s.reply_bit_level = reg_wdata_i[CTL_REPLY];
      next_s.unit_enable = reg_wdata_i[CTL_ENABLE];
    end
    if (do_wr && hit_div)
      next_s.scl_divider = reg_wdata_i;
    // clearing the valid flag with nothing queued asks for one byte
    if (do_wr && hit_flags && !reg_wdata_i[FLG_VALID] && !rx_valid && !tx_valid)
      next_s.rd_req = 1'b1;
    next_s.rdata = '0;
    if (do_rd)
    begin
      if (hit_byte)
        next_s.rdata = {8'h00, rx_valid ? rx_data : 8'h00};
      else if (hit_ctrl)
        next_s.rdata = {8'h00, ctrl_view};
      else if (hit_flags)
        next_s.rdata = {8'h00, flag_view};
      else if (hit_div)
        next_s.rdata = s.scl_divider;
    end
    // a new event beats a flag read in the same cycle
    next_s.irq_flag = evt || (s.irq_flag && !(do_rd && hit_flags));
    next_s.irq_out = next_s.irq_gate && next_s.irq_flag;
    next_s.pin_zero = 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      s <= '0;
      s.scl_sync <= 2'h3;
      s.sda_sync <= 2'h3;
      s.scl_divider <= DIVIDER_RESET;
      s.irq_gate <= CONTROL_RESET[CTL_IRQ_GATE];
      s.reply_bit_level <= CONTROL_RESET[CTL_REPLY];
      s.unit_enable <= CONTROL_RESET[CTL_ENABLE];
      s.received_reply_level <= FLAGS_RESET[FLG_REPLY];
      s.state <= ST_IDLE;
    end
    else
      s <= next_s;
  end

  // ***********************
  // outputs
  // ***********************
  assign reg_rdata_o = s.rdata;
  assign scl_o = s.pin_zero;
  assign scl_oe_o = s.scl_low;
  assign sda_o = s.pin_zero;
  assign sda_oe_o = s.sda_low;
  assign irq_o = s.irq_out;
endmodule : isc_i2c_master
`default_nettype wire

//--- rtl/isc_pkg.sv
/*
  isc_pkg: shared constants for the single-master two-wire controller.
  Assumes the register map sits at fixed absolute byte addresses.
*/
`default_nettype none
package isc_pkg;
  // ***********************
  // register map
  // ***********************
  localparam logic [31:0] ADDR_BYTE_PORT = 32'h1004_2000;
  localparam logic [31:0] ADDR_CONTROL = 32'h1004_2004;
  localparam logic [31:0] ADDR_FLAGS = 32'h1004_2008;
  localparam logic [31:0] ADDR_DIVIDER = 32'h1004_200C;
  localparam logic [15:0] DIVIDER_RESET = 16'h0000;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h04;
  // ***********************
  // control and flag bit positions
  // ***********************
  localparam int CTL_IRQ_GATE = 4;
  localparam int CTL_BEGIN = 3;
  localparam int CTL_END = 2;
  localparam int CTL_REPLY = 1;
  localparam int CTL_ENABLE = 0;
  localparam int FLG_QUEUE = 4;
  localparam int FLG_BUSY = 3;
  localparam int FLG_IDLE = 2;
  localparam int FLG_VALID = 1;
  localparam int FLG_REPLY = 0;
  // ***********************
  // timing
  // ***********************
  localparam int CLK_HZ = 25000000;
  localparam int SCL_MAX_HZ = 400000;
  localparam int QUARTERS_PER_BIT = 4;
  localparam int CLKS_PER_SCL_UNIT = 16;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  // ***********************
  // engine states
  // ***********************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_BYTE = 2'b10,
    ST_STOP = 2'b11
  } isc_state_e;
endpackage : isc_pkg
`default_nettype wire

//--- rtl/isc_buf2.sv
/*
  isc_buf2: two-entry valid/ready buffer of parameter width.
  Assumes both sides share mclk_i; a refused push is simply not taken.
*/
`default_nettype none
module isc_buf2 #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [W-1:0] in_data_i,
  // drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o
);
  typedef struct packed {
    logic [W-1:0] head;
    logic [W-1:0] tail;
    logic [1:0] cnt;
  } isc_buf_s;

  isc_buf_s s;
  isc_buf_s next_s;
  logic push;
  logic pop;

  assign in_ready_o = (s.cnt != 2'h2);
  assign out_valid_o = (s.cnt != 2'h0);
  assign out_data_o = s.head;

  always_comb
  begin
    next_s = s;
    push = in_valid_i && in_ready_o;
    pop = out_valid_o && out_ready_i;
    unique case ({push, pop})
      2'b10:
      begin
        if (s.cnt == 2'h0)
          next_s.head = in_data_i;
        else
          next_s.tail = in_data_i;
        next_s.cnt = s.cnt + 2'h1;
      end
      2'b01:
      begin
        next_s.head = s.tail;
        next_s.cnt = s.cnt - 2'h1;
      end
      2'b11:
      begin
        // one entry leaves while one arrives
        next_s.head = (s.cnt == 2'h1) ? in_data_i : s.tail;
        next_s.tail = in_data_i;
      end
      default:
      begin
        next_s = s;
      end
    endcase
  end

  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      s <= '0;
    else
      s <= next_s;
  end
endmodule : isc_buf2
`default_nettype wire

//--- dv/isc_slave_model.sv
/*
  isc_slave_model: behavioural two-wire slave for the bench.
  Assumes open-drain wires with pull-ups resolved by the bench.
*/
`default_nettype none
module isc_slave_model (
  // wire levels
  input wire logic scl_i,
  input wire logic sda_i,
  // behaviour set by the bench
  input wire logic ack_low_i,
  input wire logic rd_mode_i,
  input wire logic [7:0] rd_byte_i,
  input wire logic [15:0] stretch_ns_i,
  // pulls, high = drive wire low
  output logic scl_pull_o,
  output logic sda_pull_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = -1;
  initial scl_pull_o = 1'b0;
  // start or stop restarts the bit count
  always @(sda_i) if (scl_i === 1'b1) cnt = -1;
  // data moves only while clock low, after a hold time
  always @(negedge scl_i)
  begin
    #50 cnt = (cnt == 8) ? 0 : cnt + 1;
    if (stretch_ns_i != 16'h0000)
    begin
      scl_pull_o = 1'b1;
      #(stretch_ns_i) scl_pull_o = 1'b0;
    end
  end
  assign sda_pull_o = rd_mode_i ? (cnt >= 0 && cnt < 8 && !rd_byte_i[7 - cnt]) : (cnt == 8 && ack_low_i);
endmodule : isc_slave_model
`default_nettype wire

//--- dv/isc_i2c_master_chk.sv
/*
  isc_i2c_master_chk: port assertions for the two-wire controller.
  Assumes it is bound to isc_i2c_master and sees only its ports.
*/
`default_nettype none
module isc_i2c_master_chk import isc_pkg::*; (
  // clock and reset
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  // register port
  input wire logic reg_sel_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [31:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [15:0] reg_rdata_o,
  // pins and interrupt
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe_o,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] ctrl_q;
  logic [15:0] div_q;
  logic rd_ctl;
  logic rd_div;
  logic rd_flg;
  assign rd_ctl = reg_sel_i && reg_rd_i && reg_addr_i == ADDR_CONTROL;
  assign rd_div = reg_sel_i && reg_rd_i && reg_addr_i == ADDR_DIVIDER;
  assign rd_flg = reg_sel_i && reg_rd_i && reg_addr_i == ADDR_FLAGS;
  // ****
  // shadow of writable registers
  // ****
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ctrl_q <= CONTROL_RESET;
      div_q <= DIVIDER_RESET;
    end
    else if (reg_sel_i && reg_wr_i)
    begin
      if (reg_addr_i == ADDR_CONTROL)
        ctrl_q <= reg_wdata_i[7:0];
      if (reg_addr_i == ADDR_DIVIDER)
        div_q <= reg_wdata_i;
    end
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);
  // ****
  // assertions
  // ****
  chk_reset_quiet: assert property (@(posedge mclk_i) disable iff (1'b0)
    sys_rst_i |=> !scl_oe_o && !sda_oe_o && !irq_o && reg_rdata_o == 16'h0000)
    else $error("outputs not quiet after reset");
  chk_rdata_idle: assert property (!(reg_sel_i && reg_rd_i) |=> reg_rdata_o == 16'h0000)
    else $error("read data without a read");
  chk_ctrl_read: assert property (rd_ctl |=> reg_rdata_o == {8'h00, ctrl_q & 8'h13})
    else $error("control read mismatch");
  chk_div_read: assert property (rd_div |=> reg_rdata_o == div_q)
    else $error("divider read mismatch");
  chk_flags_reserved: assert property (rd_flg |=> reg_rdata_o[15:5] == 11'h000)
    else $error("flag reserved bits set");
  chk_irq_gated: assert property (irq_o |-> ctrl_q[CTL_IRQ_GATE])
    else $error("interrupt while gated off");
  chk_stretch_wait: assert property (!scl_oe_o && !scl_i |=> !scl_oe_o)
    else $error("clock pulled during stretch");
  chk_disabled_quiet: assert property ((!ctrl_q[CTL_ENABLE]) [*3] |-> !scl_oe_o && !sda_oe_o)
    else $error("pins driven while disabled");
  cover property ($rose(irq_o));
  cover property ((!scl_oe_o && !scl_i) [*8]);
  cover property (rd_flg ##1 reg_rdata_o[FLG_BUSY]);
endmodule : isc_i2c_master_chk
bind isc_i2c_master isc_i2c_master_chk u_chk (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
  .reg_sel_i(reg_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .scl_i(scl_i), .scl_o(scl_o),
  .scl_oe_o(scl_oe_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
`default_nettype wire

//--- dv/isc_i2c_master_tb.sv
/*
  isc_i2c_master_tb: directed bench for the two-wire controller.
  Assumes isc_slave_model on the wires and pull-ups on both lines.
*/
`default_nettype none
module isc_i2c_master_tb;
  import isc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DIV = 3;
  logic clk = 0, rst = 1, sel = 0, wr = 0, rd = 0, ack_low = 1, rd_mode = 0;
  logic scl_oe, sda_oe, scl_d, sda_d, irq, s_scl, s_sda, seen;
  logic [31:0] addr = 0;
  logic [15:0] wd = 0, q, rdata, str_ns = 0;
  logic [7:0] rd_byte = 0;
  logic [8:0] sh, got[$];
  int n_fail = 0, checks_done = 0, cyc = 0, nb = 0;
  time last, per;
  wire scl = !((scl_oe && !scl_d) || s_scl);
  wire sda = !((sda_oe && !sda_d) || s_sda);
  always #20 clk = !clk;
  isc_i2c_master dut (.mclk_i(clk), .sys_rst_i(rst), .reg_sel_i(sel), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_addr_i(addr), .reg_wdata_i(wd), .reg_rdata_o(rdata), .scl_i(scl), .scl_o(scl_d), .scl_oe_o(scl_oe),
    .sda_i(sda), .sda_o(sda_d), .sda_oe_o(sda_oe), .irq_o(irq));
  isc_slave_model slv (.scl_i(scl), .sda_i(sda), .ack_low_i(ack_low), .rd_mode_i(rd_mode),
    .rd_byte_i(rd_byte), .stretch_ns_i(str_ns), .scl_pull_o(s_scl), .sda_pull_o(s_sda));
  // ****
  // wire monitor: nine bits per byte
  // ****
  always @(negedge sda) if (scl === 1'b1) nb = 0;
  always @(posedge scl)
  begin
    per = $time - last;
    last = $time;
    sh = {sh[7:0], sda};
    nb++;
    if (nb == 9)
    begin
      got.push_back(sh);
      nb = 0;
    end
  end
  // hang guard, well above the longest run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  // ****
  // shared tasks
  // ****
  task automatic wrap_up();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic check(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : check
  // one access, then an idle edge so strobes never double up
  task automatic acc(input logic w, input logic [31:0] a, input logic [15:0] d);
    sel = 1;
    wr = w;
    rd = !w;
    addr = a;
    wd = d;
    @(posedge clk);
    #1;
    q = rdata;
    sel = 0;
    wr = 0;
    rd = 0;
    @(posedge clk);
    #1;
  endtask : acc
  task automatic rd_chk(input string n, input logic [31:0] a, input logic [15:0] e);
    acc(0, a, 16'h0000);
    check(n, q, e);
  endtask : rd_chk
  task automatic wait_flags(input string n, input logic [15:0] m, input logic [15:0] e);
    for (int i = 0; i < 1000 && (q & m) !== e; i++)
      acc(0, ADDR_FLAGS, 16'h0000);
    check(n, q & m, e);
  endtask : wait_flags
  task automatic watch_irq(input int n);
    seen = 0;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      seen = seen | irq;
    end
  endtask : watch_irq
  // ****
  // scenarios
  // ****
  task automatic t_regs();
    rd_chk("ctrl rst", ADDR_CONTROL, {8'h00, CONTROL_RESET});
    rd_chk("flags rst", ADDR_FLAGS, {8'h00, FLAGS_RESET});
    rd_chk("div rst", ADDR_DIVIDER, DIVIDER_RESET);
    acc(1, ADDR_CONTROL, 16'h00E2);
    rd_chk("ctrl rsv", ADDR_CONTROL, 16'h0002);
    acc(1, ADDR_FLAGS, 16'h00E2);
    rd_chk("flags rsv", ADDR_FLAGS, 16'h0004);
    acc(1, ADDR_DIVIDER, 16'hA5C3);
    rd_chk("div rw", ADDR_DIVIDER, 16'hA5C3);
    acc(1, 32'h1004_2010, 16'h00FF);
    rd_chk("unmapped", 32'h1004_2010, 16'h0000);
    acc(1, ADDR_DIVIDER, 16'(DIV));
  endtask : t_regs
  task automatic t_tx();
    got.delete();
    acc(1, ADDR_CONTROL, 16'h0011);
    acc(1, ADDR_CONTROL, 16'h0019);
    acc(0, ADDR_FLAGS, 16'h0000);
    check("queued", q & 16'h0010, 16'h0010);
    acc(1, ADDR_BYTE_PORT, 16'h0000);
    acc(1, ADDR_BYTE_PORT, 16'h0001);
    acc(1, ADDR_BYTE_PORT, 16'h00FF);
    wait_flags("tx done", 16'h001E, 16'h000C);
    check("two kept", 16'(got.size()), 16'h0002);
    check("general call", {7'h00, got[0]}, 16'h0000);
    check("start byte", {7'h00, got[1]}, 16'h0002);
    acc(1, ADDR_BYTE_PORT, 16'h00A5);
    acc(0, ADDR_FLAGS, 16'h0000);
    check("in progress", q & 16'h0004, 16'h0000);
    watch_irq(800);
    check("irq", {15'h0000, seen}, 16'h0001);
    check("msb first", {7'h00, got[2]}, 16'h014A);
    check("scl period", 16'(per >= 640 * (DIV + 1) && per <= 640 * (DIV + 1) + 120), 16'h0001);
    acc(0, ADDR_FLAGS, 16'h0000);
    check("irq clear", {15'h0000, irq}, 16'h0000);
    acc(1, ADDR_CONTROL, 16'h0015);
    wait_flags("stop", 16'h001E, 16'h0004);
  endtask : t_tx
  task automatic t_nack();
    ack_low = 0;
    acc(1, ADDR_CONTROL, 16'h0009);
    acc(1, ADDR_BYTE_PORT, 16'h0042);
    watch_irq(800);
    check("irq gated", {15'h0000, seen}, 16'h0000);
    wait_flags("nack", 16'h001F, 16'h000D);
    ack_low = 1;
    acc(1, ADDR_CONTROL, 16'h0005);
    wait_flags("stop nack", 16'h001E, 16'h0004);
  endtask : t_nack
  task automatic t_rx();
    acc(1, ADDR_CONTROL, 16'h0009);
    acc(1, ADDR_BYTE_PORT, 16'h00A5);
    wait_flags("addr", 16'h001F, 16'h000C);
    for (int k = 0; k < 2; k++)
    begin
      got.delete();
      rd_mode = 1;
      rd_byte = k[0] ? 8'h3C : 8'h96;
      acc(1, ADDR_CONTROL, k[0] ? 16'h0003 : 16'h0001);
      acc(1, ADDR_FLAGS, 16'h0000);
      wait_flags("rx", 16'h001E, 16'h000E);
      rd_mode = 0;
      check("rx ack", {7'h00, got[0]}, {7'h00, rd_byte, k[0]});
      rd_chk("rx byte", ADDR_BYTE_PORT, {8'h00, rd_byte});
    end
    acc(1, ADDR_CONTROL, 16'h0005);
    wait_flags("stop rx", 16'h001E, 16'h0004);
  endtask : t_rx
  task automatic t_stretch();
    got.delete();
    str_ns = 16'd2000;
    acc(1, ADDR_CONTROL, 16'h0009);
    acc(1, ADDR_BYTE_PORT, 16'h005B);
    wait_flags("stretch", 16'h001E, 16'h000C);
    check("stretch byte", {7'h00, got[0]}, 16'h00B6);
    check("stretch slow", 16'(per >= 2000), 16'h0001);
    str_ns = 16'h0000;
    acc(1, ADDR_CONTROL, 16'h0005);
    wait_flags("stop str", 16'h001E, 16'h0004);
    // disable in the middle of a byte: engine idles and lets go of both wires
    acc(1, ADDR_CONTROL, 16'h0009);
    acc(1, ADDR_BYTE_PORT, 16'h00C3);
    repeat (200) @(posedge clk);
    #1;
    acc(1, ADDR_CONTROL, 16'h0000);
    rd_chk("disable", ADDR_FLAGS, 16'h0004);
    check("released", {14'h0000, scl_oe, sda_oe}, 16'h0000);
  endtask : t_stretch
  initial
  begin
    repeat (12) @(posedge clk);
    #1;
    rst = 0;
    t_regs();
    t_tx();
    t_nack();
    t_rx();
    t_stretch();
    wrap_up();
  end
endmodule : isc_i2c_master_tb
`default_nettype wire
